/* asd_consts.svh */
// Named constants shared by both ends of the serial command link.
// Assumes inclusion by bare name from each design file that needs it.
//
// How it works
// - Oscillator runs in clock modes 00, 01, 10.
// - Internal scan time: wake, temperature, samples.
// - Modes 01 and 11 timed by host pins.
// - Bit 7 set means conversion command.
// - Modes 10/11 start on write, else pulse.
// - Skip channels used as start or reference.
// - Host never requests absent channels.
// - Host names lower channel of a pair.
// - Pair touching a reassigned pin is ignored.
// - Scan kinds: low range, high range, repeat, once.
// - One result per channel or pair (repeat: 4 to 16 of one channel), plus temperature.
// - Temperature result comes first, once per scan.
// - Bits 01 mean setup: clock, reference, pairs.
// - Pair field 1x routes next byte to pairs.
// - Host keeps select low for 16 clocks.
// - Pair field 0x leaves pair registers alone.
// - Unipolar wins over bipolar for a pair.
// - Unipolar straight binary, bipolar two's complement.
// - Bits 001 mean averaging configuration.
// - Averaging on unless external clock mode.
// - Bits 0001 reset: FIFO only or everything; full reset leaves fifo_clear low.
// - Reset state zero, setup selects mode 10.
// - Done output timing per clock mode.
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH

`define ASD_CLK_MHZ 25
`define ASD_NUM_CH 16
`define ASD_CNV_PIN 5'h0F
`define ASD_REF_PIN 5'h0E

`define ASD_T_CNV_NS 3600
`define ASD_T_TS_NS 20000
`define ASD_T_RP_NS 65000
`define ASD_T_CNV_CYC ((`ASD_T_CNV_NS * `ASD_CLK_MHZ + 999) / 1000)
`define ASD_T_TS_CYC ((`ASD_T_TS_NS * `ASD_CLK_MHZ + 999) / 1000)
`define ASD_T_RP_CYC ((`ASD_T_RP_NS * `ASD_CLK_MHZ + 999) / 1000)

`define ASD_B_CONV 7
`define ASD_B_SETUP 6
`define ASD_B_AVG 5
`define ASD_B_RST 4
`define ASD_B_RST_FIFO 3
`define ASD_B_AVG_ON 4
`define ASD_B_PAIR_WR 1
`define ASD_B_PAIR_SEL 0
`define ASD_B_TEMP 0
`define ASD_SETUP_RST 8'h20
`define ASD_REF_OFF_AFTER 2'h0
`define ASD_REF_EXT_DIFF 2'h3
`define ASD_AVG_BASE 6'h04
`define ASD_REP_STEP 3'h4

`define ASD_SCLK_HALF 4'h3
`define ASD_CS_GAP 4'h4
`define ASD_HA_TX 4'h0
`define ASD_HA_CNV 4'h1
`define ASD_HA_STAT 4'h2
`define ASD_HA_PAIR 4'h3

`endif

/* asd_pkg.sv */
// Types shared by both ends of the serial command link.
// Assumes asd_consts.svh is available on the include path.
package asd_pkg;

  typedef enum logic [1:0] {
    CLK_CONVERT_START_N_INT = 2'h0,
    CLK_CONVERT_START_N_EXT = 2'h1,
    CLK_WRITE_INT = 2'h2,
    CLK_SCLK_EXT = 2'h3
  } asd_clk_mode_type;

  typedef enum logic [1:0] {
    SCAN_LOW = 2'h0,
    SCAN_HIGH = 2'h1,
    SCAN_REPEAT = 2'h2,
    SCAN_ONCE = 2'h3
  } asd_scan_kind_type;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_WAKE = 6'h02,
    S_TEMP = 6'h04,
    S_STEP = 6'h08,
    S_WAIT = 6'h10,
    S_SAMP = 6'h20
  } asd_dev_state_type;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_SHIFT = 4'h2,
    H_HOLD = 4'h4,
    H_GAP = 4'h8
  } asd_host_state_type;

endpackage

/* asd_link_if.sv */
// Serial link between the host controller and the converter command decoder.
// Assumes both ends run on the same clk_sys; all signals are plain levels.
interface asd_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic convert_start_n_n;
  logic eoc_n;

  modport dev (
    input cs_n,
    input sclk,
    input din,
    input convert_start_n_n,
    output eoc_n
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    output convert_start_n_n,
    input eoc_n
  );
endinterface

/* asd_byte_rx.sv */
// Eight-bit MSB-first deserialiser for the device end.
// Assumes bit_stb is a one-cycle pulse per sampled serial bit.
module asd_byte_rx (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic restart,
  input wire logic bit_stb,
  input wire logic bit_in,
  output logic [7:0] byte_q,
  output logic byte_stb_q
);
  logic [2:0] cnt_q;
  logic [6:0] sh_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      sh_q <= 7'h00;
      byte_q <= 8'h00;
      byte_stb_q <= 1'b0;
    end else if (ce) begin
      byte_stb_q <= 1'b0;
      if (restart) begin
        cnt_q <= 3'h0;
      end else if (bit_stb) begin
        sh_q <= {sh_q[5:0], bit_in};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          byte_q <= {sh_q, bit_in};
          byte_stb_q <= 1'b1;
        end
      end
    end
  end
endmodule

/* asd_device.sv */
// Command decoder and scan sequencer of the multichannel converter.
// Assumes link pins are synchronous to clk_sys and the host keeps its own rules.
//
// Implementation choices: the register addresses and the strobed register port.
`include "asd_consts.svh"
module asd_device import asd_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  asd_link_if.dev link,
  input wire logic [11:0] sample_code,
  output logic result_valid,
  output logic [11:0] result_data,
  output logic [3:0] result_channel,
  output logic result_temp,
  output logic result_bipolar,
  output logic fifo_clear,
  output logic osc_run,
  output logic [1:0] timing_mode
);
  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  logic sclk_q, cs_q, cnv_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      cnv_q <= 1'b1;
    end else if (ce) begin
      sclk_q <= link.sclk;
      cs_q <= link.cs_n;
      cnv_q <= link.convert_start_n_n;
    end
  end
  logic sclk_rise, cs_fall, cs_rise, cnv_fall, cnv_rise;
  assign sclk_rise = link.sclk & ~sclk_q;
  assign cs_fall = ~link.cs_n & cs_q;
  assign cs_rise = link.cs_n & ~cs_q;
  assign cnv_fall = ~link.convert_start_n_n & cnv_q;
  assign cnv_rise = link.convert_start_n_n & ~cnv_q;

  logic [7:0] rx_byte;
  logic rx_stb;
  asd_byte_rx u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .restart(cs_fall),
    .bit_stb(sclk_rise & ~link.cs_n),
    .bit_in(link.din),
    .byte_q(rx_byte),
    .byte_stb_q(rx_stb)
  );

  // ----------------------------------------------------------------
  // Byte decode and registers
  // ----------------------------------------------------------------
  logic [7:0] conv_q, setup_q, avg_q, uni_q, bip_q;
  logic pair_pend_q;
  logic wr_pair, is_conv, is_setup, is_avg, is_rst, soft_rst;
  assign wr_pair = rx_stb & pair_pend_q;
  assign is_conv = rx_stb & ~pair_pend_q & rx_byte[`ASD_B_CONV];
  assign is_setup = rx_stb & ~pair_pend_q & (rx_byte[7:6] == 2'h1);
  assign is_avg = rx_stb & ~pair_pend_q & (rx_byte[7:5] == 3'h1);
  assign is_rst = rx_stb & ~pair_pend_q & (rx_byte[7:4] == 4'h1);
  assign soft_rst = is_rst & ~rx_byte[`ASD_B_RST_FIFO];

  asd_clk_mode_type clk_mode;
  assign clk_mode = asd_clk_mode_type'(setup_q[5:4]);
  assign timing_mode = setup_q[5:4];

  always_ff @(posedge clk_sys) begin
    if (!rst_n || (ce && soft_rst)) begin
      conv_q <= 8'h00;
      setup_q <= `ASD_SETUP_RST;
      avg_q <= 8'h00;
      uni_q <= 8'h00;
      bip_q <= 8'h00;
      pair_pend_q <= 1'b0;
    end else if (ce) begin
      if (is_conv) begin
        conv_q <= rx_byte;
      end
      if (is_setup) begin
        setup_q <= rx_byte;
      end
      if (is_avg) begin
        avg_q <= rx_byte;
      end
      if (wr_pair && setup_q[`ASD_B_PAIR_SEL]) begin
        bip_q <= rx_byte;
      end else if (wr_pair) begin
        uni_q <= rx_byte;
      end
      // no pair byte for field 0x.
      if (is_setup) begin
        pair_pend_q <= rx_byte[`ASD_B_PAIR_WR];
      end else if (wr_pair || cs_rise) begin
        pair_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fifo_clear <= 1'b0;
      osc_run <= 1'b0;
    end else if (ce) begin
      fifo_clear <= is_rst & rx_byte[`ASD_B_RST_FIFO];
      osc_run <= (clk_mode != CLK_SCLK_EXT);
    end
  end

  // ----------------------------------------------------------------
  // Channel qualification
  // ----------------------------------------------------------------
  logic [4:0] ch_q;
  logic [2:0] pidx;
  logic pen, pbip, off_lo, off_hi, cnv_used, ref_used, skip;
  logic [4:0] step;
  assign pidx = ch_q[3:1];
  assign pen = uni_q[3'h7 - pidx] | bip_q[3'h7 - pidx];
  assign pbip = bip_q[3'h7 - pidx] & ~uni_q[3'h7 - pidx];
  assign cnv_used = ~setup_q[5];
  assign ref_used = (setup_q[3:2] == `ASD_REF_EXT_DIFF);
  assign off_lo = (cnv_used && ch_q == `ASD_CNV_PIN) || (ref_used && ch_q == `ASD_REF_PIN);
  assign off_hi = (cnv_used && {ch_q[4:1], 1'b1} == `ASD_CNV_PIN) ||
                  (ref_used && {ch_q[4:1], 1'b1} == `ASD_REF_PIN);
  assign skip = pen ? (ch_q[0] | off_lo | off_hi) : off_lo;
  assign step = (pen && !ch_q[0]) ? 5'h02 : 5'h01;

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  asd_dev_state_type state_q;
  logic start_scan;
  logic [7:0] cmd;
  assign start_scan = (is_conv && clk_mode[1]) ||
                      (cnv_fall && !clk_mode[1] && state_q == S_IDLE);
  assign cmd = is_conv ? rx_byte : conv_q;

  asd_scan_kind_type kind_q;
  logic [11:0] tmr_q;
  logic [5:0] samp_q, navg;
  logic [4:0] rep_q, end_q;
  logic temp_q, done_q, finished, range_mode;
  assign range_mode = ~kind_q[1];
  assign finished = range_mode ? (ch_q > end_q) : (rep_q == 5'h00);
  assign navg = (avg_q[`ASD_B_AVG_ON] && clk_mode != CLK_SCLK_EXT) ?
                (`ASD_AVG_BASE << avg_q[3:2]) : 6'h01;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || (ce && soft_rst)) begin
      state_q <= S_IDLE;
      kind_q <= SCAN_LOW;
      tmr_q <= 12'h000;
      samp_q <= 6'h00;
      rep_q <= 5'h00;
      ch_q <= 5'h00;
      end_q <= 5'h00;
      temp_q <= 1'b0;
      done_q <= 1'b0;
      result_valid <= 1'b0;
      result_data <= 12'h000;
      result_channel <= 4'h0;
      result_temp <= 1'b0;
      result_bipolar <= 1'b0;
    end else if (ce) begin
      result_valid <= 1'b0;
      done_q <= 1'b0;
      if (start_scan) begin
        kind_q <= asd_scan_kind_type'(cmd[2:1]);
        ch_q <= (cmd[2:1] == SCAN_LOW) ? 5'h00 : {1'b0, cmd[6:3]};
        end_q <= (cmd[2:1] == SCAN_LOW) ? {1'b0, cmd[6:3]} : 5'(`ASD_NUM_CH - 1);
        rep_q <= (cmd[2:1] == SCAN_REPEAT) ? 5'({2'h0, avg_q[1:0]} + 4'h1) * `ASD_REP_STEP : 5'h01;
        temp_q <= cmd[`ASD_B_TEMP];
        if (setup_q[3:2] == `ASD_REF_OFF_AFTER) begin
          state_q <= S_WAKE;
          tmr_q <= 12'(`ASD_T_RP_CYC - 1);
        end else if (cmd[`ASD_B_TEMP]) begin
          state_q <= S_TEMP;
          tmr_q <= 12'(`ASD_T_TS_CYC - 1);
        end else begin
          state_q <= S_STEP;
        end
      end else begin
        case (state_q)
          S_IDLE: begin
            tmr_q <= 12'h000;
          end
          S_WAKE: begin
            if (tmr_q != 12'h000) begin
              tmr_q <= tmr_q - 12'h001;
            end else if (temp_q) begin
              state_q <= S_TEMP;
              tmr_q <= 12'(`ASD_T_TS_CYC - 1);
            end else begin
              state_q <= S_STEP;
            end
          end
          S_TEMP: begin
            if (tmr_q != 12'h000) begin
              tmr_q <= tmr_q - 12'h001;
            end else begin
              result_valid <= 1'b1;
              result_data <= sample_code;
              result_channel <= 4'h0;
              result_temp <= 1'b1;
              result_bipolar <= 1'b1;
              state_q <= S_STEP;
            end
          end
          S_STEP: begin
            if (finished) begin
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end else if (skip) begin
              if (range_mode) begin
                ch_q <= ch_q + 5'h01;
              end else begin
                rep_q <= 5'h00;
              end
            end else if (clk_mode == CLK_CONVERT_START_N_EXT || clk_mode == CLK_SCLK_EXT) begin
              state_q <= S_WAIT;
            end else begin
              state_q <= S_SAMP;
              tmr_q <= 12'(`ASD_T_CNV_CYC - 1);
              samp_q <= navg;
            end
          end
          S_WAIT: begin
            if (clk_mode == CLK_CONVERT_START_N_EXT && cnv_rise) begin
              state_q <= S_SAMP;
              tmr_q <= 12'(`ASD_T_CNV_CYC - 1);
              samp_q <= navg;
            end else if (clk_mode == CLK_SCLK_EXT && cs_rise) begin
              samp_q <= 6'h01;
              state_q <= S_SAMP;
              tmr_q <= 12'h000;
            end
          end
          S_SAMP: begin
            if (tmr_q != 12'h000) begin
              tmr_q <= tmr_q - 12'h001;
            end else if (samp_q > 6'h01) begin
              samp_q <= samp_q - 6'h01;
              tmr_q <= 12'(`ASD_T_CNV_CYC - 1);
            end else begin
              result_valid <= 1'b1;
              result_data <= (pen && pbip) ? {~sample_code[11], sample_code[10:0]} : sample_code;
              result_channel <= ch_q[3:0];
              result_temp <= 1'b0;
              result_bipolar <= pen & pbip;
              if (range_mode) begin
                ch_q <= ch_q + step;
              end else begin
                rep_q <= rep_q - 5'h01;
              end
              state_q <= S_STEP;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion-done output
  // ----------------------------------------------------------------
  logic eoc_q;
  assign link.eoc_n = eoc_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (ce && soft_rst)) begin
      eoc_q <= 1'b1;
    end else if (ce) begin
      if (clk_mode == CLK_SCLK_EXT || cs_fall || cnv_fall) begin
        eoc_q <= 1'b1;
      end else if (done_q && (clk_mode == CLK_CONVERT_START_N_INT || clk_mode == CLK_WRITE_INT)) begin
        eoc_q <= 1'b0;
      end else if (result_valid && clk_mode == CLK_CONVERT_START_N_EXT) begin
        eoc_q <= 1'b0;
      end
    end
  end
endmodule

/* asd_host.sv */
// Host controller: serial master that sends command bytes and start pulses.
// Assumes software drives the plain register port, one strobe per cycle.
`include "asd_consts.svh"
module asd_host import asd_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  asd_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  asd_host_state_type state_q;
  logic cs_n_q, sclk_q, din_q, convert_start_n_q;
  logic [3:0] div_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q, uni_sh_q, bip_sh_q, cnv_cnt_q;
  logic pair_next_q, pair_sel_q, in_pair_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.din = din_q;
  assign link.convert_start_n_n = convert_start_n_q;

  // ----------------------------------------------------------------
  // Byte acceptance
  // ----------------------------------------------------------------
  logic [7:0] tx;
  logic [2:0] tidx;
  logic tx_ok, tx_go;
  assign tidx = wdata[6:4];
  always_comb begin
    tx = wdata[7:0];
    if (!pair_next_q && tx[`ASD_B_CONV] && tx[3] &&
        (uni_sh_q[3'h7 - tidx] || bip_sh_q[3'h7 - tidx])) begin
      tx[3] = 1'b0;
    end
  end
  assign tx_ok = pair_next_q || !tx[`ASD_B_CONV] || ({1'b0, tx[6:3]} < 5'(`ASD_NUM_CH));
  assign tx_go = wr && addr == `ASD_HA_TX && tx_ok && (state_q == H_IDLE || state_q == H_HOLD);

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= H_IDLE;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      div_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      pair_next_q <= 1'b0;
      pair_sel_q <= 1'b0;
      in_pair_q <= 1'b0;
      uni_sh_q <= 8'h00;
      bip_sh_q <= 8'h00;
    end else if (ce) begin
      case (state_q)
        H_IDLE, H_HOLD: begin
          if (tx_go) begin
            state_q <= H_SHIFT;
            cs_n_q <= 1'b0;
            din_q <= tx[7];
            sh_q <= tx;
            div_q <= `ASD_SCLK_HALF - 4'h1;
            bit_q <= 3'h0;
            in_pair_q <= pair_next_q;
            if (pair_next_q && pair_sel_q) begin
              bip_sh_q <= tx;
            end else if (pair_next_q) begin
              uni_sh_q <= tx;
            end
            if (!pair_next_q && tx[7:6] == 2'h1) begin
              pair_next_q <= tx[`ASD_B_PAIR_WR];
              pair_sel_q <= tx[`ASD_B_PAIR_SEL];
            end else begin
              pair_next_q <= 1'b0;
            end
            if (!pair_next_q && tx[7:4] == 4'h1 && !tx[`ASD_B_RST_FIFO]) begin
              uni_sh_q <= 8'h00;
              bip_sh_q <= 8'h00;
            end
          end
        end
        H_SHIFT: begin
          // serial clock period sets link timing.
          if (div_q != 4'h0) begin
            div_q <= div_q - 4'h1;
          end else begin
            div_q <= `ASD_SCLK_HALF - 4'h1;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              if (bit_q == 3'h7) begin
                // select held low across both bytes.
                if (pair_next_q && !in_pair_q) begin
                  state_q <= H_HOLD;
                end else begin
                  state_q <= H_GAP;
                  cs_n_q <= 1'b1;
                  div_q <= `ASD_CS_GAP - 4'h1;
                end
              end else begin
                bit_q <= bit_q + 3'h1;
                sh_q <= {sh_q[6:0], 1'b0};
                din_q <= sh_q[6];
              end
            end
          end
        end
        H_GAP: begin
          if (div_q != 4'h0) begin
            div_q <= div_q - 4'h1;
          end else begin
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Convert-start pulse and register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      convert_start_n_q <= 1'b1;
      cnv_cnt_q <= 8'h00;
    end else if (ce) begin
      // low pulse starts scan in modes 00 and 01.
      if (wr && addr == `ASD_HA_CNV && convert_start_n_q) begin
        convert_start_n_q <= 1'b0;
        cnv_cnt_q <= (wdata[7:0] == 8'h00) ? 8'h00 : wdata[7:0] - 8'h01;
      end else if (!convert_start_n_q && cnv_cnt_q != 8'h00) begin
        cnv_cnt_q <= cnv_cnt_q - 8'h01;
      end else begin
        convert_start_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      if (rd && addr == `ASD_HA_STAT) begin
        rdata <= {11'h000, pair_next_q, ~convert_start_n_q, state_q == H_HOLD,
                  state_q == H_SHIFT || state_q == H_GAP, ~link.eoc_n};
      end else if (rd && addr == `ASD_HA_PAIR) begin
        rdata <= {bip_sh_q, uni_sh_q};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end
endmodule

/* asd_link_monitor.sv */
// ---------------------------------------------------------------
// Checker for the serial link between host and command decoder.
// ---------------------------------------------------------------
// Assumes one clk_sys domain; tb instantiates it beside the link.
module asd_link_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic convert_start_n_n,
  input wire logic eoc_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [4:0] rise_cnt_q;
  // Serial edges counted per frame, since frames must hold whole bytes.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || cs_n) begin
      rise_cnt_q <= 5'h00;
    end else if ($rose(sclk)) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("Serial clock not low outside a frame.");
  a_din_held_rise: assert property ($rose(sclk) |-> $stable(din))
    else $error("Serial data moved at the sampling edge.");
  a_sclk_half_period: assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
    else $error("Serial clock high phase is not three cycles.");
  a_cs_high_gap: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("Chip select gap is shorter than four cycles.");
  a_frame_whole_bytes: assert property ($rose(cs_n) |->
    rise_cnt_q[2:0] == 3'h0 && rise_cnt_q != 5'h00)
    else $error("Frame did not carry whole bytes.");
  a_done_clr_select: assert property ($fell(cs_n) |-> ##[1:3] eoc_n)
    else $error("Done stayed low after select fell.");
  a_done_clr_start: assert property ($fell(convert_start_n_n) |-> ##[1:3] eoc_n)
    else $error("Done stayed low after start fell.");
  a_done_reset_high: assert property ($rose(rst_n) |-> eoc_n)
    else $error("Done not high after reset.");
endmodule

/* tb.sv */
// ---------------------------------------------------------------
// Testbench: host register port drives the decoder over the link.
// ---------------------------------------------------------------
// Assumes both ends share clk_sys; results are seen at the device.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, st;
  logic [11:0] code = 12'h5A3, got_dat [8];
  logic [3:0] got_ch [8];
  logic got_tmp [8], got_bip [8], res_valid, res_temp, res_bip, fclr, fc_seen = 1'b0;
  logic [11:0] res_data;
  logic [3:0] res_ch;
  logic osc_run;
  logic [1:0] tmode;
  int n_res = 0, fail_count = 0, tests_run = 0, cyc = 0;
  asd_link_if link ();
  asd_device asd_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .link(link.dev),
    .sample_code(code), .result_valid(res_valid), .result_data(res_data),
    .result_channel(res_ch), .result_temp(res_temp), .result_bipolar(res_bip),
    .fifo_clear(fclr), .osc_run(osc_run), .timing_mode(tmode));
  asd_host asd_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .link(link.host),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  asd_link_monitor asd_link_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .convert_start_n_n(link.convert_start_n_n), .eoc_n(link.eoc_n));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (res_valid === 1'b1 && n_res < 8) begin
      got_ch[n_res] = res_ch;
      got_tmp[n_res] = res_temp;
      got_bip[n_res] = res_bip;
      got_dat[n_res] = res_data;
      n_res++;
    end
    if (fclr === 1'b1) fc_seen = 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask
  // Poll the busy flag so a byte is never dropped by the host.
  task automatic send(input logic [7:0] b);
    wr_reg(4'h0, {8'h00, b});
    st = 16'h0002;
    for (int i = 0; i < 300 && st[1] !== 1'b0; i++) rd_reg(4'h2, st);
    chk("tx_idle", 16'h0, {15'h0, st[1]});
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && link.eoc_n !== 1'b0; i++) @(posedge clk_sys);
    chk("eoc_done", 16'h0, {15'h0, link.eoc_n});
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("timing_mode", 16'h2, {14'h0, tmode});
    chk("osc_run", 16'h1, {15'h0, osc_run});
    send(8'h97);
    wait_done();
    chk("result_count", 16'h2, n_res[15:0]);
    chk("first_temp", 16'h1, {15'h0, got_tmp[0]});
    chk("chan", 16'h2, {12'h0, got_ch[1]});
    chk("data_uni", {4'h0, code}, {4'h0, got_dat[1]});
    wr_reg(4'h1, 16'h0004);
    repeat (6) @(posedge clk_sys);
    chk("eoc_after_start", 16'h1, {15'h0, link.eoc_n});
    send(8'h1D);
    send(8'h05);
    chk("fifo_clear", 16'h1, {15'h0, fc_seen});
    chk("mode_kept", 16'h2, {14'h0, tmode});
    // Reference kept on, so no wake delay holds back the frame-end result.
    send(8'h78);
    chk("mode_ext", 16'h3, {14'h0, tmode});
    chk("osc_off", 16'h0, {15'h0, osc_run});
    n_res = 0;
    send(8'h9E);
    repeat (20) @(posedge clk_sys);
    chk("ext_count", 16'h1, n_res[15:0]);
    chk("ext_chan", 16'h3, {12'h0, got_ch[0]});
    chk("ext_eoc", 16'h1, {15'h0, link.eoc_n});
    send(8'h10);
    chk("full_reset", 16'h2, {14'h0, tmode});
    // Bipolar first, then unipolar on the same pair, which must win.
    for (int k = 0; k < 2; k++) begin
      send(k == 0 ? 8'h63 : 8'h62);
      send(8'h80);
      n_res = 0;
      send(8'h86);
      wait_done();
      chk("pair_bip", {15'h0, k == 0}, {15'h0, got_bip[0]});
      chk("pair_data", {4'h0, code ^ (k == 0 ? 12'h800 : 12'h000)},
        {4'h0, got_dat[0]});
    end
    rd_reg(4'h3, st);
    chk("pair_shadow", 16'h8080, st);
    // Mode 00: high range from 12; channel 15 is the start pin and is skipped.
    send(8'h48);
    send(8'hE2);
    n_res = 0;
    wr_reg(4'h1, 16'h0002);
    wait_done();
    chk("scan_count", 16'h3, n_res[15:0]);
    chk("scan_first", 16'hC, {12'h0, got_ch[0]});
    chk("scan_last", 16'hE, {12'h0, got_ch[2]});
    // Mode 01: one result timed by the start pulse.
    send(8'h58);
    send(8'hAE);
    n_res = 0;
    wr_reg(4'h1, 16'h0008);
    wait_done();
    chk("pulse_count", 16'h1, n_res[15:0]);
    chk("pulse_chan", 16'h5, {12'h0, got_ch[0]});
    close_out();
  end
endmodule
